// File: rtl/t2co_defs.svh
`ifndef T2CO_DEFS_SVH
`define T2CO_DEFS_SVH

// register bus
`define T2CO_ADDR_W 8
`define T2CO_DATA_W 32
`define T2CO_CTRL_OFFS 8'hc8
`define T2CO_MODE_OFFS 8'hcc
`define T2CO_RELOAD_OFFS 8'hd0
`define T2CO_COUNT_OFFS 8'hd4

// reset values
`define T2CO_CTRL_RST 8'h00
`define T2CO_MODE_RST 2'h0
`define T2CO_WORD_RST 16'h0000

// timing
`define T2CO_FOSC_HZ 10000000
`define T2CO_FAST_DIV 2
`define T2CO_TIMER_DIV 12
`define T2CO_COUNT_MAX 16'hffff

`endif

// File: rtl/t2co_pkg.sv
`include "t2co_defs.svh"

package t2co_pkg;

  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic serial_rx_clock_select;
    logic serial_tx_clock_select;
    logic external_trigger_enable;
    logic run_control;
    logic timer_counter_select;
    logic capture_reload_select;
  } t2co_ctrl_t;

  typedef struct packed {
    logic clock_output_enable;
    logic up_down_enable;
  } t2co_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`T2CO_ADDR_W-1:0] paddr;
    logic [`T2CO_DATA_W-1:0] pwdata;
  } t2co_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [`T2CO_DATA_W-1:0] prdata;
  } t2co_apb_rsp_t;

  typedef enum logic [4:0] {
    T2CO_STOP = 5'b00001,
    T2CO_CAPTURE = 5'b00010,
    T2CO_RELOAD = 5'b00100,
    T2CO_UPDOWN = 5'b01000,
    T2CO_BAUD = 5'b10000
  } t2co_mode_sel_t;

endpackage : t2co_pkg

// File: rtl/t2co_prescale.sv
`timescale 1ns/1ps
`include "t2co_defs.svh"

module t2co_prescale #(
  parameter int unsigned DIV [2] = '{`T2CO_FAST_DIV, `T2CO_TIMER_DIV}
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // one-cycle ticks, one per divisor
  output logic [1:0] tick
);

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_div
      localparam logic [3:0] LAST = 4'(DIV[i] - 1);
      logic [3:0] div_ff;
      logic [3:0] nxt_div;
      logic tick_ff;
      logic nxt_tick;
      always_comb
      begin
        nxt_tick = (div_ff == LAST);
        nxt_div = nxt_tick ? 4'h0 : div_ff + 4'h1;
      end
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          div_ff <= 4'h0;
          tick_ff <= 1'b0;
        end
        else
        begin
          div_ff <= nxt_div;
          tick_ff <= nxt_tick;
        end
      end
      assign tick[i] = tick_ff;
    end
  endgenerate

endmodule : t2co_prescale

// File: rtl/t2co_fall_det.sv
`timescale 1ns/1ps

module t2co_fall_det #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels and their falling edges
  input wire logic [W-1:0] level,
  output logic [W-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic prev_ff;
      logic nxt_prev;
      always_comb
      begin
        nxt_prev = level[i];
      end
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          prev_ff <= 1'b0;
        end
        else
        begin
          prev_ff <= nxt_prev;
        end
      end
      assign fall[i] = prev_ff & ~level[i];
    end
  endgenerate

endmodule : t2co_fall_det

// File: rtl/t2co_top.sv
`timescale 1ns/1ps
`include "t2co_defs.svh"

module t2co_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire t2co_pkg::t2co_apb_req_t apb_req,
  output t2co_pkg::t2co_apb_rsp_t apb_rsp,
  // timer pin, shared with port bit 0
  input wire logic timer_io_pin_level,
  input wire logic port_latch_bit0,
  output logic timer_io_pin_drive,
  output logic timer_io_pin_oe_n,
  // trigger pin
  input wire logic external_trigger_pin,
  // serial clocks and interrupt
  input wire logic timer1_overflow,
  output logic serial_rx_clock,
  output logic serial_tx_clock,
  output logic timer_irq_req
);
  import t2co_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  t2co_ctrl_t ctrl_ff, nxt_ctrl;
  t2co_mode_t mode_ff, nxt_mode;
  logic [15:0] reload_ff, nxt_reload;
  logic [15:0] count_ff, nxt_count;
  logic pin_ff, nxt_pin;
  logic oe_n_ff, nxt_oe_n;
  logic rx_ff, nxt_rx;
  logic tx_ff, nxt_tx;
  logic irq_ff, nxt_irq;
  t2co_apb_rsp_t rsp_ff, nxt_rsp;

  logic [1:0] tick;
  logic [1:0] fall;
  logic baud_mode;
  logic clk_out_mode;
  logic cnt_tick;
  logic trig_fall;
  logic count_up;
  logic ovf;
  logic unf;
  logic capture;
  logic trig_reload;
  t2co_mode_sel_t mode_sel;
  logic acc;
  logic ctrl_wr;
  logic mode_wr;
  logic rel_wr;
  logic cnt_wr;

  ////////////////////////////////////////////////////////////////////////////
  // ticks and edges
  t2co_prescale u_prescale (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  t2co_fall_det #(.W(2)) u_fall (
    .clk(clk),
    .rst_n(rst_n),
    .level({external_trigger_pin, timer_io_pin_level}),
    .fall(fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign baud_mode = ctrl_ff.serial_rx_clock_select | ctrl_ff.serial_tx_clock_select;
  assign clk_out_mode = mode_ff.clock_output_enable & ~ctrl_ff.timer_counter_select;
  assign trig_fall = fall[1] & ctrl_ff.external_trigger_enable;
  assign count_up = external_trigger_pin;

  always_comb
  begin
    // oscillator tick or pin falls
    if (ctrl_ff.timer_counter_select)
    begin
      cnt_tick = fall[0];
    end
    else if (clk_out_mode || baud_mode)
    begin
      cnt_tick = tick[0];
    end
    else
    begin
      cnt_tick = tick[1];
    end
  end

  always_comb
  begin
    if (!ctrl_ff.run_control)
    begin
      mode_sel = T2CO_STOP;
    end
    else if (baud_mode)
    begin
      mode_sel = T2CO_BAUD;
    end
    else if (ctrl_ff.capture_reload_select)
    begin
      mode_sel = T2CO_CAPTURE;
    end
    else if (mode_ff.up_down_enable)
    begin
      mode_sel = T2CO_UPDOWN;
    end
    else
    begin
      mode_sel = T2CO_RELOAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter
  always_comb
  begin
    nxt_count = count_ff;
    ovf = 1'b0;
    unf = 1'b0;
    capture = 1'b0;
    trig_reload = 1'b0;
    unique case (mode_sel)
      T2CO_STOP:
      begin
        nxt_count = count_ff;
      end
      T2CO_BAUD, T2CO_RELOAD:
      begin
        if (cnt_tick && count_ff == `T2CO_COUNT_MAX)
        begin
          nxt_count = reload_ff;
          ovf = 1'b1;
        end
        else if (cnt_tick)
        begin
          nxt_count = count_ff + 16'h0001;
        end
        if (mode_sel == T2CO_RELOAD && trig_fall)
        begin
          nxt_count = reload_ff;
          trig_reload = 1'b1;
        end
      end
      T2CO_CAPTURE:
      begin
        if (cnt_tick && count_ff == `T2CO_COUNT_MAX)
        begin
          nxt_count = clk_out_mode ? reload_ff : `T2CO_WORD_RST;
          ovf = 1'b1;
        end
        else if (cnt_tick)
        begin
          nxt_count = count_ff + 16'h0001;
        end
        capture = trig_fall;
      end
      T2CO_UPDOWN:
      begin
        if (cnt_tick && count_up && count_ff == `T2CO_COUNT_MAX)
        begin
          nxt_count = reload_ff;
          ovf = 1'b1;
        end
        else if (cnt_tick && count_up)
        begin
          nxt_count = count_ff + 16'h0001;
        end
        else if (cnt_tick && count_ff == reload_ff)
        begin
          nxt_count = `T2CO_COUNT_MAX;
          unf = 1'b1;
        end
        else if (cnt_tick)
        begin
          nxt_count = count_ff - 16'h0001;
        end
      end
    endcase
    if (cnt_wr)
    begin
      nxt_count = apb_req.pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and flags
  always_comb
  begin
    nxt_ctrl = ctrl_wr ? t2co_ctrl_t'(apb_req.pwdata[7:0]) : ctrl_ff;
    if ((ovf || unf) && !baud_mode && !clk_out_mode)
    begin
      nxt_ctrl.overflow_flag = 1'b1;
    end
    if (mode_sel == T2CO_UPDOWN && (ovf || unf))
    begin
      nxt_ctrl.external_event_flag = ~ctrl_ff.external_event_flag;
    end
    else if (capture || trig_reload)
    begin
      nxt_ctrl.external_event_flag = 1'b1;
    end
    nxt_mode = mode_wr ? t2co_mode_t'(apb_req.pwdata[1:0]) : mode_ff;
    nxt_reload = reload_ff;
    if (rel_wr)
    begin
      nxt_reload = apb_req.pwdata[15:0];
    end
    else if (capture)
    begin
      nxt_reload = count_ff;
    end
    nxt_irq = ctrl_ff.overflow_flag
      | (ctrl_ff.external_event_flag & ~mode_ff.up_down_enable);
    nxt_rx = ctrl_ff.serial_rx_clock_select ? ovf : timer1_overflow;
    nxt_tx = ctrl_ff.serial_tx_clock_select ? ovf : timer1_overflow;
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer pin
  always_comb
  begin
    if (mode_ff.clock_output_enable)
    begin
      nxt_pin = ovf ? ~pin_ff : pin_ff;
      nxt_oe_n = 1'b0;
    end
    else
    begin
      nxt_pin = port_latch_bit0;
      nxt_oe_n = port_latch_bit0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  assign acc = apb_req.psel & apb_req.penable & rsp_ff.pready;
  assign ctrl_wr = acc & apb_req.pwrite & (apb_req.paddr == `T2CO_CTRL_OFFS);
  assign mode_wr = acc & apb_req.pwrite & (apb_req.paddr == `T2CO_MODE_OFFS);
  assign rel_wr = acc & apb_req.pwrite & (apb_req.paddr == `T2CO_RELOAD_OFFS);
  assign cnt_wr = acc & apb_req.pwrite & (apb_req.paddr == `T2CO_COUNT_OFFS);

  always_comb
  begin
    nxt_rsp = rsp_ff;
    nxt_rsp.pready = apb_req.psel & ~apb_req.penable;
    nxt_rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable)
    begin
      nxt_rsp.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        `T2CO_CTRL_OFFS: nxt_rsp.prdata = {24'h000000, ctrl_ff};
        `T2CO_MODE_OFFS: nxt_rsp.prdata = {30'h0, mode_ff};
        `T2CO_RELOAD_OFFS: nxt_rsp.prdata = {16'h0000, reload_ff};
        `T2CO_COUNT_OFFS: nxt_rsp.prdata = {16'h0000, count_ff};
        default: nxt_rsp.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= t2co_ctrl_t'(`T2CO_CTRL_RST);
      mode_ff <= t2co_mode_t'(`T2CO_MODE_RST);
      reload_ff <= `T2CO_WORD_RST;
      count_ff <= `T2CO_WORD_RST;
      pin_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      rx_ff <= 1'b0;
      tx_ff <= 1'b0;
      irq_ff <= 1'b0;
      rsp_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      reload_ff <= nxt_reload;
      count_ff <= nxt_count;
      pin_ff <= nxt_pin;
      oe_n_ff <= nxt_oe_n;
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      irq_ff <= nxt_irq;
      rsp_ff <= nxt_rsp;
    end
  end

  assign apb_rsp = rsp_ff;
  assign timer_io_pin_drive = pin_ff;
  assign timer_io_pin_oe_n = oe_n_ff;
  assign serial_rx_clock = rx_ff;
  assign serial_tx_clock = tx_ff;
  assign timer_irq_req = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable && apb_rsp.pready;
  endsequence

  a_apb_ready: assert property (s_setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready not one cycle after setup");
  a_apb_write: assert property (s_access ##0 (apb_req.pwrite)
      && apb_req.paddr == `T2CO_RELOAD_OFFS |=> reload_ff == $past(apb_req.pwdata[15:0]))
    else $error("reload write lost");
  a_fast_tick: assert property (tick[0] |=> !tick[0] ##1 tick[0])
    else $error("fast tick not every second cycle");
  a_slow_tick: assert property (tick[1] |=> !tick[1] [*8])
    else $error("timer tick too frequent");
  a_reload_ovf: assert property (ovf && !cnt_wr && (mode_sel != T2CO_CAPTURE || clk_out_mode)
      |=> count_ff == $past(reload_ff))
    else $error("overflow did not reload count");
  a_ovf_no_flag: assert property ((baud_mode || clk_out_mode) && !ctrl_wr
      && !ctrl_ff.overflow_flag |=> !ctrl_ff.overflow_flag)
    else $error("overflow flag set in serial or clock-out mode");
  a_ovf_flag_set: assert property (ovf && !baud_mode && !clk_out_mode
      |=> ctrl_ff.overflow_flag)
    else $error("overflow flag not set");
  a_pin_toggle: assert property (mode_ff.clock_output_enable && ovf
      |=> timer_io_pin_drive != $past(timer_io_pin_drive))
    else $error("clock pin did not toggle on overflow");
  a_pin_steady: assert property (mode_ff.clock_output_enable && !ovf
      |=> $stable(timer_io_pin_drive))
    else $error("clock pin changed without overflow");
  a_pin_driven: assert property (mode_ff.clock_output_enable |=> !timer_io_pin_oe_n)
    else $error("clock pin not driven");
  a_run_stop: assert property (!ctrl_ff.run_control && !cnt_wr |=> $stable(count_ff))
    else $error("count moved while stopped");
  a_trig_ignore: assert property (!ctrl_ff.external_trigger_enable && !ctrl_wr
      && !ctrl_ff.external_event_flag && mode_sel != T2CO_UPDOWN
      |=> !ctrl_ff.external_event_flag)
    else $error("disabled trigger set external flag");
  a_capture_val: assert property (capture && !rel_wr
      |=> reload_ff == $past(count_ff) && ctrl_ff.external_event_flag)
    else $error("capture failed");
  a_rx_select: assert property (ctrl_ff.serial_rx_clock_select
      |=> serial_rx_clock == $past(ovf))
    else $error("receive clock not from own overflow");
  a_tx_select: assert property (!ctrl_ff.serial_tx_clock_select
      |=> serial_tx_clock == $past(timer1_overflow))
    else $error("transmit clock not from timer1");
  a_irq_updown: assert property (mode_ff.up_down_enable && !ctrl_ff.overflow_flag
      |=> !timer_irq_req)
    else $error("external flag interrupt in up/down mode");

endmodule : t2co_top

// File: sim/t2co_clk_sink.sv
`timescale 1ns/1ps

module t2co_clk_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timer pin, pulled up when nobody drives it
  input wire logic pin_drive,
  input wire logic pin_oe_n,
  output logic pin_level,
  // measured half periods
  output int hi_len,
  output int lo_len,
  output int n_edges
);
  logic prev;
  int cnt;

  assign pin_level = pin_oe_n ? 1'b1 : pin_drive;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev <= 1'b1;
      cnt <= 1;
      n_edges <= 0;
      hi_len <= 0;
      lo_len <= 0;
    end
    else if (pin_level !== prev)
    begin
      if (prev)
        hi_len <= cnt;
      else
        lo_len <= cnt;
      cnt <= 1;
      n_edges <= n_edges + 1;
      prev <= pin_level;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : t2co_clk_sink

// File: sim/tb.sv
`timescale 1ns/1ps
`include "t2co_defs.svh"
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      n_errors++; \
      $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end

module tb;
  import t2co_pkg::*;
  logic clk;
  logic rst_n;
  t2co_apb_req_t apb_req;
  t2co_apb_rsp_t apb_rsp;
  logic pin_level;
  logic pin_drive;
  logic pin_oe_n;
  logic trig;
  logic latch;
  logic t1_ovf;
  logic rx_clk;
  logic tx_clk;
  logic irq;
  logic [31:0] rd;
  logic [31:0] keep;
  logic err;
  int n_errors;
  int n_tests;
  int hi_len;
  int lo_len;
  int n_edges;

  t2co_top u_dut (.clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .timer_io_pin_level(pin_level), .port_latch_bit0(latch), .timer_io_pin_drive(pin_drive),
    .timer_io_pin_oe_n(pin_oe_n), .external_trigger_pin(trig), .timer1_overflow(t1_ovf),
    .serial_rx_clock(rx_clk), .serial_tx_clock(tx_clk), .timer_irq_req(irq));

  t2co_clk_sink u_sink (.clk(clk), .rst_n(rst_n), .pin_drive(pin_drive),
    .pin_oe_n(pin_oe_n), .pin_level(pin_level), .hi_len(hi_len), .lo_len(lo_len),
    .n_edges(n_edges));

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wdata;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n >= 20)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    end
  endtask : apb

  task automatic pulse_trig();
    @(posedge clk);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    trig <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : pulse_trig

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'h0)
    apb(0, `T2CO_RELOAD_OFFS, 0);
    `CHK(rd, 32'h0)
    apb(0, 8'h10, 0);
    `CHK({err, rd}, 33'h100000000)
    apb(1, `T2CO_MODE_OFFS, 32'hffffffff);
    apb(0, `T2CO_MODE_OFFS, 0);
    `CHK(rd, 32'h3)
    apb(1, `T2CO_MODE_OFFS, 0);
    repeat (2) @(posedge clk);
    `CHK(pin_oe_n, 1'b1)
    @(posedge clk);
    t1_ovf <= 1'b1;
    @(posedge clk);
    t1_ovf <= 1'b0;
    @(posedge clk);
    `CHK({rx_clk, tx_clk}, 2'b11)
    $display("test reset done");
  endtask : t_reset

  task automatic t_clock_out();
    int e0;
    apb(1, `T2CO_MODE_OFFS, 32'h2);
    apb(1, `T2CO_CTRL_OFFS, 32'h0);
    apb(1, `T2CO_RELOAD_OFFS, 32'hfff0);
    apb(1, `T2CO_COUNT_OFFS, 32'hfff0);
    apb(1, `T2CO_CTRL_OFFS, 32'h4);
    e0 = n_edges;
    for (int i = 0; i < 400 && n_edges < e0 + 4; i++)
      @(posedge clk);
    `CHK(hi_len, 2 * (65536 - 32'hfff0))
    `CHK(lo_len, 2 * (65536 - 32'hfff0))
    `CHK({pin_oe_n, irq}, 2'b00)
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'h4)
    apb(1, `T2CO_CTRL_OFFS, 32'h0);
    apb(1, `T2CO_MODE_OFFS, 32'h0);
    $display("test clock out done");
  endtask : t_clock_out

  task automatic t_overflow();
    apb(1, `T2CO_RELOAD_OFFS, 32'h1234);
    apb(1, `T2CO_COUNT_OFFS, 32'hfffe);
    apb(1, `T2CO_CTRL_OFFS, 32'h4);
    repeat (40) @(posedge clk);
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'h84)
    `CHK(irq, 1'b1)
    apb(0, `T2CO_COUNT_OFFS, 0);
    `CHK(rd[15:4], 12'h123)
    apb(1, `T2CO_CTRL_OFFS, 32'h0);
    apb(0, `T2CO_COUNT_OFFS, 0);
    keep = rd;
    repeat (30) @(posedge clk);
    apb(0, `T2CO_COUNT_OFFS, 0);
    `CHK(rd, keep)
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK({rd[7:0], irq}, 9'h0)
    $display("test overflow done");
  endtask : t_overflow

  task automatic t_trigger();
    apb(1, `T2CO_RELOAD_OFFS, 32'h4000);
    apb(1, `T2CO_COUNT_OFFS, 32'h0100);
    apb(1, `T2CO_CTRL_OFFS, 32'hc);
    pulse_trig();
    apb(0, `T2CO_COUNT_OFFS, 0);
    `CHK(rd[15:1], 15'h2000)
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'h4c)
    `CHK(irq, 1'b1)
    apb(1, `T2CO_CTRL_OFFS, 32'h4);
    pulse_trig();
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'h4)
    apb(1, `T2CO_CTRL_OFFS, 32'hd);
    apb(1, `T2CO_COUNT_OFFS, 32'h0500);
    pulse_trig();
    apb(0, `T2CO_RELOAD_OFFS, 0);
    `CHK(rd[15:1], 15'h0280)
    apb(1, `T2CO_CTRL_OFFS, 32'h0);
    $display("test trigger done");
  endtask : t_trigger

  task automatic t_serial();
    logic seen_rx;
    logic seen_tx;
    int e0;
    seen_rx = 1'b0;
    seen_tx = 1'b0;
    apb(1, `T2CO_MODE_OFFS, 32'h2);
    apb(1, `T2CO_RELOAD_OFFS, 32'hfff0);
    apb(1, `T2CO_COUNT_OFFS, 32'hfff0);
    apb(1, `T2CO_CTRL_OFFS, 32'h35);
    e0 = n_edges;
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clk);
      seen_rx |= (rx_clk === 1'b1);
      seen_tx |= (tx_clk === 1'b1);
    end
    `CHK({seen_rx, seen_tx}, 2'b11)
    `CHK(hi_len, 2 * (65536 - 32'hfff0))
    `CHK(n_edges > e0 + 3, 1'b1)
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'h35)
    apb(1, `T2CO_CTRL_OFFS, 32'h0);
    $display("test serial done");
  endtask : t_serial

  task automatic t_updown();
    @(posedge clk);
    trig <= 1'b0;
    apb(1, `T2CO_MODE_OFFS, 32'h1);
    apb(1, `T2CO_RELOAD_OFFS, 32'h1000);
    apb(1, `T2CO_COUNT_OFFS, 32'h1001);
    apb(1, `T2CO_CTRL_OFFS, 32'h4);
    repeat (40) @(posedge clk);
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'hc4)
    apb(0, `T2CO_COUNT_OFFS, 0);
    `CHK(rd[15:4], 12'hfff)
    apb(1, `T2CO_CTRL_OFFS, 32'h44);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    trig <= 1'b1;
    apb(1, `T2CO_COUNT_OFFS, 32'hfffe);
    repeat (40) @(posedge clk);
    apb(0, `T2CO_CTRL_OFFS, 0);
    `CHK(rd, 32'h84)
    `CHK(irq, 1'b1)
    apb(0, `T2CO_COUNT_OFFS, 0);
    `CHK(rd[15:4], 12'h100)
    apb(1, `T2CO_CTRL_OFFS, 32'h0);
    apb(1, `T2CO_MODE_OFFS, 32'h0);
    $display("test updown done");
  endtask : t_updown

  task automatic t_counter();
    apb(1, `T2CO_MODE_OFFS, 32'h0);
    apb(1, `T2CO_COUNT_OFFS, 32'h0);
    apb(1, `T2CO_CTRL_OFFS, 32'h6);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      latch <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK({pin_oe_n, pin_level}, 2'b00)
      latch <= 1'b1;
      repeat (2) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    apb(0, `T2CO_COUNT_OFFS, 0);
    `CHK(rd, 32'h5)
    apb(1, `T2CO_CTRL_OFFS, 32'h0);
    $display("test counter done");
  endtask : t_counter

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #(100 * 20000);
    n_errors++;
    stop_test();
  end

  initial
  begin
    n_errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    apb_req = '0;
    trig = 1'b1;
    latch = 1'b1;
    t1_ovf = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_clock_out();
    t_overflow();
    t_trigger();
    t_serial();
    t_updown();
    t_counter();
    stop_test();
  end
endmodule : tb
